// [pllc_timing_ctrl.sv]
// pllc_timing_ctrl: register file, i2c address match, pll feedback and
// lock detector, adc and synthesis dividers, reference selection.
// assumes: a serial front end hands over decoded address phases and
// register strobes on ref_clk; ref_clk stands in for the pll clock.
`timescale 1ns/100ps
`default_nettype none
module pllc_timing_ctrl #(
    parameter logic [6:0] OWN_ADDR = 7'h5E // arbitrary device address
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic i2c_mode,
    input wire logic addr_valid,
    input wire logic [6:0] addr_target,
    input wire logic addr_read,
    input wire logic i2c_stop,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic ext_ref_clock_pin,
    output logic addr_ack,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic pll_locked,
    output logic phase_unlock,
    output logic pll_feedback_tick,
    output logic [10:0] pll_mult_factor,
    output logic adc_clk_tick,
    output logic dac_clk_tick,
    output logic [8:0] stim_dac_ratio,
    output logic [10:0] rx_adc_ratio,
    output logic [11:0] ref_period_cycles
);
    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [7:0] bcast_reg;
    logic [7:0] pll_hi_reg;
    logic [7:0] mult_lo_reg;
    logic [7:0] lock_win_reg;
    logic [7:0] ref_cfg_reg;
    logic [7:0] meas_cfg_reg;
    pllc_pkg::pllc_sess_e sess_reg;
    pllc_pkg::pllc_sess_e sess_next;

    logic broadcast_write_enable;
    logic [6:0] broadcast_target_address;
    logic [9:0] pll_feedback_multiplier;
    logic adc_clock_divider_select;
    logic [3:0] synth_clock_divider;
    logic pll_enable;
    logic lock_detect_window;
    logic ref_source_ext;
    logic ref_freq_select;
    logic [4:0] osc_trim;
    logic [1:0] stim_dac_oversample;
    logic [2:0] rx_adc_oversample;
    logic bandgap_enable;
    logic inphase_channel_enable;
    logic quadrature_channel_enable;

    assign broadcast_write_enable = bcast_reg[pllc_pkg::BCAST_EN_BIT];
    assign broadcast_target_address = bcast_reg[pllc_pkg::BCAST_ADDR_LSB +: 7];
    assign pll_feedback_multiplier = {pll_hi_reg[pllc_pkg::MULT_HI_LSB +: 2], mult_lo_reg};
    assign adc_clock_divider_select = pll_hi_reg[pllc_pkg::ADC_DIV_BIT];
    assign synth_clock_divider = pll_hi_reg[pllc_pkg::SYNTH_DIV_LSB +: 4];
    assign pll_enable = pll_hi_reg[pllc_pkg::PLL_EN_BIT];
    assign lock_detect_window = lock_win_reg[pllc_pkg::LOCK_WIN_BIT];
    assign ref_source_ext = ref_cfg_reg[pllc_pkg::REF_SEL_BIT];
    assign ref_freq_select = ref_cfg_reg[pllc_pkg::FREQ_SEL_BIT];
    assign osc_trim = ref_cfg_reg[pllc_pkg::TRIM_LSB +: 5];
    assign stim_dac_oversample = meas_cfg_reg[pllc_pkg::DAC_OSR_LSB +: 2];
    assign rx_adc_oversample = meas_cfg_reg[pllc_pkg::ADC_OSR_LSB +: 3];
    assign bandgap_enable = meas_cfg_reg[pllc_pkg::BG_EN_BIT];
    assign inphase_channel_enable = meas_cfg_reg[pllc_pkg::I_EN_BIT];
    assign quadrature_channel_enable = meas_cfg_reg[pllc_pkg::Q_EN_BIT];

    // decode shared by the read mux and the write path
    function automatic logic is_offset(input logic [7:0] a, input logic [7:0] ofs);
        is_offset = (a == ofs);
    endfunction : is_offset

    // ------------------------------------------------------------------
    // i2c session: own address or broadcast write
    // ------------------------------------------------------------------
    logic bcast_hit;
    logic own_hit;
    assign own_hit = (addr_target == OWN_ADDR);
    // broadcast only takes writes, so a read to it is never acknowledged
    assign bcast_hit = broadcast_write_enable && !addr_read
        && (addr_target == broadcast_target_address);

    always_comb begin
        sess_next = sess_reg;
        if (!i2c_mode) begin
            sess_next = pllc_pkg::SESS_IDLE; // spi: broadcast address unused
        end else if (addr_valid) begin
            if (own_hit) begin
                sess_next = pllc_pkg::SESS_OWN;
            end else if (bcast_hit) begin
                sess_next = pllc_pkg::SESS_BCAST;
            end else begin
                sess_next = pllc_pkg::SESS_IDLE;
            end
        end else if (i2c_stop) begin
            sess_next = pllc_pkg::SESS_IDLE;
        end
    end

    // session state and address acknowledge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sess_reg <= pllc_pkg::SESS_IDLE;
            addr_ack <= 1'b0;
        end else begin
            sess_reg <= sess_next;
            addr_ack <= i2c_mode && addr_valid && (own_hit || bcast_hit);
        end
    end

    // strobes allowed through: spi always, i2c only inside a session
    logic wr_ok;
    logic rd_ok;
    always_comb begin
        wr_ok = 1'b0;
        rd_ok = 1'b0;
        case (sess_reg)
            pllc_pkg::SESS_OWN: begin
                wr_ok = reg_wr;
                rd_ok = reg_rd;
            end
            pllc_pkg::SESS_BCAST: begin
                wr_ok = reg_wr; // reads refused in broadcast
            end
            pllc_pkg::SESS_IDLE: begin
                wr_ok = reg_wr && !i2c_mode;
                rd_ok = reg_rd && !i2c_mode;
            end
            default: begin
                wr_ok = 1'b0;
                rd_ok = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bcast_reg <= pllc_pkg::RST_BCAST;
            pll_hi_reg <= pllc_pkg::RST_PLL_HI;
            mult_lo_reg <= pllc_pkg::RST_MULT_LO;
            lock_win_reg <= pllc_pkg::RST_LOCK_WIN;
            ref_cfg_reg <= pllc_pkg::RST_REF_CFG;
            meas_cfg_reg <= pllc_pkg::RST_MEAS_CFG;
        end else if (wr_ok) begin
            if (is_offset(reg_addr, pllc_pkg::OFS_BCAST)) bcast_reg <= reg_wdata;
            if (is_offset(reg_addr, pllc_pkg::OFS_PLL_HI)) pll_hi_reg <= reg_wdata;
            if (is_offset(reg_addr, pllc_pkg::OFS_MULT_LO)) mult_lo_reg <= reg_wdata;
            if (is_offset(reg_addr, pllc_pkg::OFS_LOCK_WIN)) begin
                lock_win_reg <= {7'h00, reg_wdata[0]}; // upper bits reserved
            end
            if (is_offset(reg_addr, pllc_pkg::OFS_REF_CFG)) begin
                ref_cfg_reg <= {1'b0, reg_wdata[6:0]}; // bit 7 reserved
            end
            if (is_offset(reg_addr, pllc_pkg::OFS_MEAS_CFG)) meas_cfg_reg <= reg_wdata;
        end
    end

    // self-clearing resync; ignored while any measurement block is on
    logic resync_pulse;
    logic meas_idle;
    assign meas_idle = !bandgap_enable && !inphase_channel_enable && !quadrature_channel_enable;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            resync_pulse <= 1'b0;
        end else begin
            resync_pulse <= wr_ok && is_offset(reg_addr, pllc_pkg::OFS_RESYNC)
                && reg_wdata[pllc_pkg::RESYNC_BIT] && meas_idle;
        end
    end

    // ------------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00; // unmapped and resync read as zero
        if (is_offset(reg_addr, pllc_pkg::OFS_BCAST)) rd_mux = bcast_reg;
        if (is_offset(reg_addr, pllc_pkg::OFS_PLL_HI)) rd_mux = pll_hi_reg;
        if (is_offset(reg_addr, pllc_pkg::OFS_MULT_LO)) rd_mux = mult_lo_reg;
        if (is_offset(reg_addr, pllc_pkg::OFS_LOCK_WIN)) rd_mux = lock_win_reg;
        if (is_offset(reg_addr, pllc_pkg::OFS_REF_CFG)) rd_mux = ref_cfg_reg;
        if (is_offset(reg_addr, pllc_pkg::OFS_MEAS_CFG)) rd_mux = meas_cfg_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            rd_valid <= rd_ok;
            if (rd_ok) rd_data <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // reference: internal oscillator model or external pin
    // ------------------------------------------------------------------
    // period shrinks as trim raises the frequency; signed 0.2 % steps
    logic [11:0] osc_period;
    always_comb begin
        int base;
        int adj;
        base = ref_freq_select ? int'(pllc_pkg::REF_PERIOD_B_CYC)
            : int'(pllc_pkg::REF_PERIOD_A_CYC);
        adj = (base * int'($signed(osc_trim)) * pllc_pkg::TRIM_STEP_PER_MILLE) / 1000;
        osc_period = 12'(base - adj);
    end

    logic [11:0] osc_cnt_reg;
    logic osc_tick;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            osc_cnt_reg <= 12'h000;
            osc_tick <= 1'b0;
            ref_period_cycles <= pllc_pkg::REF_PERIOD_A_CYC;
        end else begin
            ref_period_cycles <= osc_period;
            if (osc_cnt_reg >= osc_period - 12'h001) begin
                osc_cnt_reg <= 12'h000;
                osc_tick <= 1'b1;
            end else begin
                osc_cnt_reg <= osc_cnt_reg + 12'h001;
                osc_tick <= 1'b0;
            end
        end
    end

    // pin passes three flops; a level counts once the last two agree
    logic [2:0] ext_sync_reg;
    logic ext_level_reg;
    logic ext_rise;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ext_sync_reg <= 3'h0;
            ext_level_reg <= 1'b0;
        end else begin
            ext_sync_reg <= {ext_sync_reg[1:0], ext_ref_clock_pin};
            if (ext_sync_reg[1] == ext_sync_reg[2]) ext_level_reg <= ext_sync_reg[2];
        end
    end
    assign ext_rise = (ext_sync_reg[1] == ext_sync_reg[2]) && ext_sync_reg[2] && !ext_level_reg;

    logic ref_edge;
    assign ref_edge = ref_source_ext ? ext_rise : osc_tick;

    // ------------------------------------------------------------------
    // feedback divider and lock detector
    // ------------------------------------------------------------------
    logic [9:0] fb_cnt_reg;
    logic [10:0] fb_period;
    logic [10:0] dist_since;
    logic [10:0] dist_until;
    logic [10:0] phase_err;
    logic [10:0] win_periods;
    logic in_window;
    assign fb_period = {1'b0, pll_feedback_multiplier} + 11'h001;
    assign dist_since = {1'b0, fb_cnt_reg};
    assign dist_until = fb_period - dist_since;
    assign phase_err = (dist_since < dist_until) ? dist_since : dist_until;
    assign win_periods = lock_detect_window ? 11'h002 : 11'h001;
    assign in_window = phase_err < win_periods;

    // out-of-window edges realign the divider, as the loop would pull in
    always_ff @(posedge ref_clk) begin
        if (rst || !pll_enable) begin
            fb_cnt_reg <= 10'h000;
            pll_feedback_tick <= 1'b0;
        end else if (ref_edge && !in_window) begin
            fb_cnt_reg <= 10'h001; // ref edge cycle was count 0, so a match reads 0
            pll_feedback_tick <= 1'b1;
        end else if (fb_cnt_reg >= pll_feedback_multiplier) begin
            fb_cnt_reg <= 10'h000;
            pll_feedback_tick <= 1'b1;
        end else begin
            fb_cnt_reg <= fb_cnt_reg + 10'h001;
            pll_feedback_tick <= 1'b0;
        end
    end

    // lock state is judged at every reference rising edge
    always_ff @(posedge ref_clk) begin
        if (rst || !pll_enable) begin
            pll_locked <= 1'b0;
            phase_unlock <= 1'b0;
        end else begin
            phase_unlock <= ref_edge && !in_window && pll_locked;
            if (ref_edge) pll_locked <= in_window;
        end
    end

    // ------------------------------------------------------------------
    // clock dividers and oversampling decode
    // ------------------------------------------------------------------
    logic [3:0] adc_shift;
    logic [3:0] synth_shift;
    assign adc_shift = adc_clock_divider_select ? pllc_pkg::ADC_SHIFT_1024
        : pllc_pkg::ADC_SHIFT_512;
    assign synth_shift = (synth_clock_divider > pllc_pkg::SYNTH_SHIFT_MAX)
        ? pllc_pkg::SYNTH_SHIFT_MAX : synth_clock_divider;

    pllc_pow2_div u_adc_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .run(pll_enable),
        .clear(resync_pulse),
        .shift(adc_shift),
        .tick(adc_clk_tick)
    );

    pllc_pow2_div u_dac_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .run(pll_enable),
        .clear(1'b0),
        .shift(synth_shift),
        .tick(dac_clk_tick)
    );

    // ratios and multiplier factor presented from flops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stim_dac_ratio <= pllc_pkg::DAC_OSR_BASE;
            rx_adc_ratio <= pllc_pkg::ADC_OSR_BASE;
            pll_mult_factor <= 11'h000;
        end else begin
            stim_dac_ratio <= 9'(pllc_pkg::DAC_OSR_BASE << stim_dac_oversample);
            rx_adc_ratio <= 11'(pllc_pkg::ADC_OSR_BASE << rx_adc_oversample);
            pll_mult_factor <= fb_period;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    logic [10:0] adc_gap_reg;
    logic adc_gap_void_reg;
    always_ff @(posedge ref_clk) begin
        if (rst || resync_pulse || !pll_enable || adc_clk_tick) begin
            adc_gap_reg <= 11'h000;
            adc_gap_void_reg <= rst || resync_pulse || !pll_enable;
        end else begin
            adc_gap_reg <= adc_gap_reg + 11'h001;
            if (wr_ok && is_offset(reg_addr, pllc_pkg::OFS_PLL_HI)) adc_gap_void_reg <= 1'b1;
        end
    end

    sequence bcast_address_phase;
        i2c_mode && addr_valid && !addr_read && broadcast_write_enable
            && addr_target == broadcast_target_address && addr_target != OWN_ADDR;
    endsequence

    sequence bcast_session_held;
        sess_reg == pllc_pkg::SESS_BCAST;
    endsequence

    a_bcast_select: assert property (@(posedge ref_clk) disable iff (rst)
        bcast_address_phase |=> bcast_session_held ##0 addr_ack)
        else $error("broadcast write address not accepted");

    a_bcast_read_refused: assert property (@(posedge ref_clk) disable iff (rst)
        bcast_session_held ##0 reg_rd |=> !rd_valid)
        else $error("read answered inside broadcast session");

    a_spi_no_session: assert property (@(posedge ref_clk) disable iff (rst)
        !i2c_mode |=> sess_reg == pllc_pkg::SESS_IDLE && !addr_ack)
        else $error("address phase honoured in spi mode");

    a_adc_div_period: assert property (@(posedge ref_clk) disable iff (rst)
        adc_clk_tick && !adc_gap_void_reg
            |-> adc_gap_reg == (adc_clock_divider_select ? 11'd1023 : 11'd511))
        else $error("adc clock tick spacing wrong");

    a_resync_gated: assert property (@(posedge ref_clk) disable iff (rst)
        reg_wr && !meas_idle |=> !resync_pulse)
        else $error("resync taken while measurement enabled");

    a_lock_window: assert property (@(posedge ref_clk) disable iff (rst)
        pll_enable && ref_edge && phase_err < win_periods ##1 pll_enable |-> pll_locked)
        else $error("lock not declared inside window");

    a_unlock_pulse: assert property (@(posedge ref_clk) disable iff (rst)
        pll_enable && pll_locked && ref_edge && phase_err >= win_periods ##1 pll_enable
            |-> phase_unlock && !pll_locked ##1 !phase_unlock)
        else $error("loss of lock not flagged as one pulse");

    a_osr_decode: assert property (@(posedge ref_clk) disable iff (rst)
        rx_adc_oversample == 3'h7 && stim_dac_oversample == 2'h3
            |=> rx_adc_ratio == 11'd1024 && stim_dac_ratio == 9'd256)
        else $error("oversampling ratio decode wrong");

endmodule : pllc_timing_ctrl
`default_nettype wire

// [pllc_pkg.sv]
// pllc_pkg: register map, field layout, reset values and timing counts
// for the timing-control block.
// assumes: a 125 MHz core clock that stands in for the PLL output clock.
package pllc_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_RESYNC = 8'h10; // timing resync trigger
    localparam logic [7:0] OFS_BCAST = 8'h14;
    localparam logic [7:0] OFS_PLL_HI = 8'h17;
    localparam logic [7:0] OFS_MULT_LO = 8'h18;
    localparam logic [7:0] OFS_LOCK_WIN = 8'h19;
    localparam logic [7:0] OFS_REF_CFG = 8'h1A;
    localparam logic [7:0] OFS_MEAS_CFG = 8'h20;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_BCAST = 8'h00;
    localparam logic [7:0] RST_PLL_HI = 8'h40;
    localparam logic [7:0] RST_MULT_LO = 8'hBB;
    localparam logic [7:0] RST_LOCK_WIN = 8'h00;
    localparam logic [7:0] RST_REF_CFG = 8'h00;
    localparam logic [7:0] RST_MEAS_CFG = 8'h00;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BCAST_EN_BIT = 0;
    localparam int BCAST_ADDR_LSB = 1;
    localparam int MULT_HI_LSB = 6;
    localparam int ADC_DIV_BIT = 5;
    localparam int SYNTH_DIV_LSB = 1;
    localparam int PLL_EN_BIT = 0;
    localparam int LOCK_WIN_BIT = 0;
    localparam int REF_SEL_BIT = 6;
    localparam int FREQ_SEL_BIT = 5;
    localparam int TRIM_LSB = 0;
    localparam int DAC_OSR_LSB = 6;
    localparam int ADC_OSR_LSB = 3;
    localparam int BG_EN_BIT = 2;
    localparam int Q_EN_BIT = 1;
    localparam int I_EN_BIT = 0;
    localparam int RESYNC_BIT = 0;

    // ------------------------------------------------------------------
    // divider and ratio constants
    // ------------------------------------------------------------------
    localparam logic [3:0] ADC_SHIFT_512 = 4'h9;
    localparam logic [3:0] ADC_SHIFT_1024 = 4'hA;
    localparam logic [3:0] SYNTH_SHIFT_MAX = 4'hD; // divide by 8192
    localparam logic [8:0] DAC_OSR_BASE = 9'h020; // 32
    localparam logic [10:0] ADC_OSR_BASE = 11'h008; // 8

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam longint CLK_FREQ_HZ = 125_000_000;
    localparam longint REF_FREQ_A_HZ = 32_000;
    localparam longint REF_FREQ_B_MHZ = 32_768; // 32.768 khz, given in hz
    localparam logic [11:0] REF_PERIOD_A_CYC = 12'(CLK_FREQ_HZ / REF_FREQ_A_HZ);
    localparam logic [11:0] REF_PERIOD_B_CYC = 12'(CLK_FREQ_HZ * 1000 / (REF_FREQ_B_MHZ * 1000));
    localparam int TRIM_STEP_PER_MILLE = 2; // 0.2 % per trim step

    // i2c session states
    typedef enum logic [2:0] {
        SESS_IDLE = 3'b001,
        SESS_OWN = 3'b010,
        SESS_BCAST = 3'b100
    } pllc_sess_e;

endpackage : pllc_pkg

// [pllc_pow2_div.sv]
// pllc_pow2_div: power-of-two clock divider producing a one-cycle tick.
// assumes: shift is held stable by the owner; a clear restarts the count.
`timescale 1ns/100ps
`default_nettype none
module pllc_pow2_div (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic clear,
    input wire logic [3:0] shift,
    output logic tick
);
    logic [13:0] cnt_reg;
    logic [13:0] last_cnt;

    // terminal count is 2**shift - 1; shift 0 gives a tick every cycle
    assign last_cnt = 14'((15'h0001 << shift) - 15'h0001);

    // ------------------------------------------------------------------
    // counter and tick
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst || clear || !run) begin
            cnt_reg <= 14'h0000;
            tick <= 1'b0;
        end else if (cnt_reg >= last_cnt) begin
            cnt_reg <= 14'h0000; // >= also recovers from a shrunken shift
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 14'h0001;
            tick <= 1'b0;
        end
    end
endmodule : pllc_pow2_div
`default_nettype wire

// [pllc_host_model.sv]
// pllc_host_model: host on the register port, spi or i2c front end.
// assumes: the bench calls one task at a time on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module pllc_host_model (
    input wire logic ref_clk,
    input wire logic addr_ack,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    output logic i2c_mode,
    output logic addr_valid,
    output logic [6:0] addr_target,
    output logic addr_read,
    output logic i2c_stop,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    // quiet bus in spi mode at time zero
    initial {i2c_mode, addr_valid, addr_target, addr_read, i2c_stop} = '0;
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    task automatic mode(input logic m);
        @(posedge ref_clk);
        i2c_mode <= m;
    endtask : mode
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // answer lands on the strobe edge; read it once settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        v = rd_valid;
        d = rd_data;
    endtask : rd
    // reads to the broadcast address only when the bench asks for a refusal
    task automatic adr(input logic [6:0] t, input logic r, output logic k);
        @(posedge ref_clk);
        addr_target <= t;
        addr_read <= r;
        addr_valid <= 1'b1;
        @(posedge ref_clk);
        addr_valid <= 1'b0;
        #1;
        k = addr_ack;
    endtask : adr
    task automatic stop;
        @(posedge ref_clk);
        i2c_stop <= 1'b1;
        @(posedge ref_clk);
        i2c_stop <= 1'b0;
    endtask : stop
endmodule : pllc_host_model
`default_nettype wire

// [pll_timing_config_bench.sv]
// pll_timing_config_bench: self-checking bench for pllc_timing_ctrl.
// assumes: 125 mhz ref_clk; the host model drives the register port.
`timescale 1ns/100ps
`default_nettype none
module pll_timing_config_bench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic pin = 1'b0;
    logic m, av, ard, stp, w, r, ack, rv, atk, dtk, k, v, lk, pu;
    logic [6:0] at;
    logic [7:0] ra, wd, rdat, d;
    logic [10:0] mf, ax;
    logic [8:0] dr;
    logic [11:0] rp;
    int num_errors = 0;
    int n_tests = 0;
    int n;
    always #4 ref_clk = ~ref_clk;
    // external reference of 3906 core cycles, changed on the clock edge
    always begin
        repeat (1953) @(posedge ref_clk);
        pin <= ~pin;
    end
    pllc_host_model HOST (.ref_clk(ref_clk), .addr_ack(ack), .rd_valid(rv), .rd_data(rdat),
        .i2c_mode(m), .addr_valid(av), .addr_target(at), .addr_read(ard), .i2c_stop(stp),
        .reg_wr(w), .reg_rd(r), .reg_addr(ra), .reg_wdata(wd));
    pllc_timing_ctrl DUT (.ref_clk(ref_clk), .rst(rst), .i2c_mode(m), .addr_valid(av),
        .addr_target(at), .addr_read(ard), .i2c_stop(stp), .reg_wr(w), .reg_rd(r),
        .reg_addr(ra), .reg_wdata(wd), .ext_ref_clock_pin(pin), .addr_ack(ack),
        .rd_valid(rv), .rd_data(rdat), .pll_locked(lk), .phase_unlock(pu),
        .pll_feedback_tick(), .pll_mult_factor(mf), .adc_clk_tick(atk), .dac_clk_tick(dtk),
        .stim_dac_ratio(dr), .rx_adc_ratio(ax), .ref_period_cycles(rp));
    task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    // cycles until the next tick, sampled once the edge has settled
    task automatic gap(input bit dac);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while ((dac ? dtk : atk) !== 1'b1 && n < 20000);
    endtask : gap
    // cycles between two ticks; the first tick after a change is skipped
    task automatic per(input bit dac);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
        end while ((dac ? dtk : atk) !== 1'b1 && ++n < 20000);
        gap(dac);
    endtask : per
    task automatic t_reset;
        logic [7:0] ofs [7] = '{8'h14, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h20, 8'h15};
        logic [7:0] val [7] = '{8'h00, 8'h40, 8'hBB, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 7; i++) begin
            HOST.rd(ofs[i], d, v);
            chk("reset value", d, val[i]);
        end
        chk("multiplier", mf, 16'h01BC);
        chk("ref period", rp, 16'h0F42);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_osr;
        for (int c = 0; c < 8; c++) begin
            HOST.wr(8'h20, 8'(c % 4 * 64 + c * 8));
            @(posedge ref_clk);
            #1;
            chk("dac ratio", dr, 16'h0020 << c[1:0]);
            chk("adc ratio", ax, 16'h0008 << c);
        end
        HOST.wr(8'h20, 8'h00);
        $display("t_osr done");
    endtask : t_osr
    task automatic t_ref;
        HOST.wr(8'h1A, 8'h20);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("ref period", rp, 16'h0EE6);
        $display("t_ref done");
    endtask : t_ref
    task automatic t_bcast;
        HOST.wr(8'h14, 8'h67);
        HOST.mode(1'b1);
        HOST.adr(7'h33, 1'b0, k);
        chk("bcast ack", k, 16'h1);
        HOST.wr(8'h19, 8'h01);
        HOST.rd(8'h19, d, v);
        chk("bcast read", v, 16'h0);
        HOST.stop;
        HOST.adr(7'h33, 1'b1, k);
        chk("bcast read ack", k, 16'h0);
        HOST.mode(1'b0);
        HOST.adr(7'h33, 1'b0, k);
        chk("spi ack", k, 16'h0);
        HOST.rd(8'h19, d, v);
        chk("bcast write", d, 16'h01);
        $display("t_bcast done");
    endtask : t_bcast
    // pll enable set first, as the host must
    task automatic t_div;
        logic [3:0] code [3] = '{4'h3, 4'hD, 4'hF};
        HOST.wr(8'h17, 8'h81);
        per(1'b0);
        chk("adc div", n, 16'd512);
        chk("multiplier", mf, 16'h02BC);
        // divider restarts the cycle after the strobe edge
        HOST.wr(8'h10, 8'h01);
        gap(1'b0);
        chk("resync", n, 16'd513);
        HOST.wr(8'h20, 8'h04);
        HOST.wr(8'h10, 8'h01);
        HOST.wr(8'h20, 8'h00);
        gap(1'b0);
        chk("resync refused", n, 16'd506); // 512 less six write cycles
        HOST.wr(8'h17, 8'hA1);
        per(1'b0);
        chk("adc div", n, 16'd1024);
        for (int i = 0; i < 3; i++) begin
            HOST.wr(8'h81, 8'h00);
            HOST.wr(8'h17, 8'h81 | {3'h0, code[i], 1'b0});
            per(1'b1);
            chk("dac div", n, 16'h1 << (code[i] > 13 ? 13 : code[i]));
        end
        $display("t_div done");
    endtask : t_div
    // pll clock 651 x 32 khz stays inside 14 to 28 mhz
    task automatic t_lock;
        HOST.wr(8'h1A, 8'h00);
        HOST.wr(8'h19, 8'h00); // clean reference, narrow window
        HOST.wr(8'h18, 8'h8A);
        repeat (12000) @(posedge ref_clk);
        #1;
        chk("locked", lk, 16'h1);
        HOST.wr(8'h18, 8'h8B);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
        end while (pu !== 1'b1 && ++n < 9000);
        chk("unlock", {pu, lk}, 16'h2);
        HOST.wr(8'h1A, 8'h40);
        HOST.wr(8'h18, 8'h8A);
        repeat (12000) @(posedge ref_clk);
        #1;
        chk("pin lock", lk, 16'h1);
        $display("t_lock done");
    endtask : t_lock
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        t_reset;
        t_osr;
        t_ref;
        t_bcast;
        t_div;
        t_lock;
        end_of_test;
    end
    // whole run is about 62k cycles; allow 95k
    initial begin
        #760_000;
        num_errors++;
        end_of_test;
    end
endmodule : pll_timing_config_bench
`default_nettype wire
